/* File: rtl/bsp_top.sv */
// boot strap capture, pin multiplexing and fast io port
// assumes pads resolve wires from the enables; reset is async low
// Contract
// R1: each muxed pin takes its first function at reset; firmware may remap
// R2: reset pin is open drain, input at start, may drive low when enabled
// R3: reset pin high at power-up boots application, low boots rom
// R4: fast port is 16 bits with write, set, clear, toggle ops
// R5: only lower ten fast port bits reach pins
// R6: fast bits reset as inputs, pull-ups off, unless muxed away
// R7: bit 9 shares debug pin; bits 9..6 can carry interrupts
// R8: bits 1 and 0 go to host i2c data and clock at reset
// R9: wake input triggers on rise, fall, high or low; wakes sleep
// R10: wake input is a priority 7 interrupt
// R11: debug pin low at start gives debug boot, high or floating normal
// R12: in debug state the debug pin is a two-way single wire port
// R13: slave select low at start picks spi, high picks i2c
// R14: interface choice is a strap given to boot code, not fixed logic
// R15: host interrupt output only reflects the command complete flag
// R16: host holds slave select at the matching level during reset
// R17: with i2c picked, port bit 3 is general io driving low
// R18: spi master returns slave select high after each transaction
// R19: host holds slave select low after a reset command until reset
// R20: host holds slave select low 1 ms past reset pin release
// R21: straps are latched once at reset exit and held until next reset
`timescale 1ns/100ps
module bsp_top #(
  parameter int W = bsp_pkg::FIO_WIDTH,
  parameter int P = bsp_pkg::FIO_PINS
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 ce_in,
  // reset pin, open drain
  input  wire logic                 reset_pin_n_in,
  output logic                      reset_pin_n_out,
  output logic                      reset_pin_n_oe_out,
  input  wire logic                 reset_drive_in,
  input  wire logic                 reset_bidir_en_in,
  // device pins of the fast port
  input  wire logic [P-1:0]         pin_in,
  output logic      [P-1:0]         pin_out,
  output logic      [P-1:0]         pin_oe_out,
  output logic      [P-1:0]         pin_pullup_out,
  // firmware controls
  input  wire bsp_pkg::bsp_fio_cmd_s fio_cmd_in,
  input  wire logic [W-1:0]         fio_dir_in,
  input  wire logic                 fio_dir_we_in,
  input  wire logic [W-1:0]         fio_pull_in,
  input  wire logic                 fio_pull_we_in,
  input  wire logic [2*P-1:0]       mux_sel_in,
  input  wire logic                 mux_we_in,
  input  wire logic [1:0]           wake_mode_in,
  input  wire logic                 wake_ack_in,
  input  wire logic                 command_complete_flag_in,
  input  wire logic [3:0]           irq_src_in,
  // alternate function links
  input  wire logic                 host_i2c_data_out_in,
  input  wire logic                 host_i2c_data_oe_in,
  input  wire logic                 host_i2c_clock_oe_in,
  input  wire logic                 debug_wire_out_in,
  input  wire logic                 debug_wire_oe_in,
  output logic                      debug_wire_out,
  output logic                      host_i2c_data_out,
  output logic                      host_i2c_clock_out,
  output logic                      slave_select_n_out,
  // results
  output logic [W-1:0]              fio_data_out,
  output logic [W-1:0]              fio_in_out,
  output bsp_pkg::bsp_straps_s      straps_out,
  output logic                      straps_valid_out,
  output logic                      background_debug_state_out,
  output logic                      wake_irq_out,
  output logic [2:0]                wake_level_out
);
  typedef struct packed {
    bsp_pkg::bsp_state_e   state;
    logic [3:0]            cnt;
    bsp_pkg::bsp_straps_s  straps;
    logic [W-1:0]          data;
    logic [W-1:0]          dir;
    logic [W-1:0]          pull;
    logic [2*P-1:0]        mux;
  } bsp_top_s;

  bsp_top_s    st_reg;
  bsp_top_s    st_next;
  logic [P-1:0] pin_s;
  logic        rst_pin_s;
  logic        wake_hit;

  // external pins are asynchronous; filter through three stages
  bsp_sync #(.WIDTH(P), .INIT({P{1'b1}})) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .async_in   (pin_in),
    .sync_out   (pin_s)
  );
  bsp_sync #(.WIDTH(1), .INIT(1'b1)) u_rst_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .async_in   (reset_pin_n_in),
    .sync_out   (rst_pin_s)
  );

  // wake detector on bit 4 pin
  bsp_wake u_wake (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .wake_in    (pin_s[bsp_pkg::BIT_WAKE]),
    .mode_in    (wake_mode_in),
    .ack_in     (wake_ack_in),
    .irq_out    (wake_hit)
  );

  // strap capture sequence and fast port update
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg.state)
      bsp_pkg::ST_WAIT:
      begin
        // let the synchronisers fill before sampling straps
        st_next.cnt = st_reg.cnt + 4'h1;
        if (st_reg.cnt == 4'(bsp_pkg::STRAP_CYCLES + bsp_pkg::SYNC_STAGES))
          st_next.state = bsp_pkg::ST_LATCH;
      end
      bsp_pkg::ST_LATCH:
      begin
        st_next.straps.boot_app   = rst_pin_s; // R3 R21
        st_next.straps.debug_boot = ~pin_s[bsp_pkg::BIT_DEBUG]; // R11 R21
        st_next.straps.slave_spi  = ~pin_s[bsp_pkg::BIT_PORT3]; // R13 R21
        if (pin_s[bsp_pkg::BIT_PORT3])
        begin
          // i2c chosen: bit 3 becomes io, output low
          st_next.dir[bsp_pkg::BIT_PORT3]  = 1'b1; // R17
          st_next.data[bsp_pkg::BIT_PORT3] = 1'b0; // R17
        end
        else
          st_next.mux[2*bsp_pkg::BIT_PORT3 +: 2] = bsp_pkg::FUNC_3;
        st_next.state = bsp_pkg::ST_RUN;
      end
      bsp_pkg::ST_RUN:
      begin
        if (fio_cmd_in.valid)
        begin
          unique case (fio_cmd_in.op) // R4
            bsp_pkg::OP_WRITE:  st_next.data = fio_cmd_in.data;
            bsp_pkg::OP_SET:    st_next.data = st_reg.data | fio_cmd_in.data;
            bsp_pkg::OP_CLEAR:  st_next.data = st_reg.data & ~fio_cmd_in.data;
            bsp_pkg::OP_TOGGLE: st_next.data = st_reg.data ^ fio_cmd_in.data;
          endcase
        end
        if (fio_dir_we_in)
          st_next.dir = fio_dir_in;
        if (fio_pull_we_in)
          st_next.pull = fio_pull_in;
        if (mux_we_in)
          st_next.mux = mux_sel_in; // R1
      end
      default:
        st_next.state = bsp_pkg::ST_WAIT;
    endcase
  end

  // all state resets to inputs, pull-ups off, first functions
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_reg       <= '0; // R1 R6
      st_reg.state <= bsp_pkg::ST_WAIT;
    end
    else if (ce_in)
      st_reg <= st_next;
  end

  // per pin output mux; function 1 = default, others alternate
  generate
    for (genvar i = 0; i < P; i++)
    begin : g_pin
      logic [1:0] f;
      logic       io_o;
      logic       io_e;
      logic       alt_o;
      logic       alt_e;
      assign f    = st_reg.mux[2*i +: 2];
      assign io_o = st_reg.data[i];
      assign io_e = st_reg.dir[i];
      always_comb
      begin
        alt_o = io_o;
        alt_e = io_e;
        if (i == bsp_pkg::BIT_I2C_DAT && f == bsp_pkg::FUNC_1)
        begin
          alt_o = host_i2c_data_out_in; // R8
          alt_e = host_i2c_data_oe_in;
        end
        else if (i == bsp_pkg::BIT_I2C_CLK && f == bsp_pkg::FUNC_1)
        begin
          alt_o = 1'b0; // R8
          alt_e = host_i2c_clock_oe_in;
        end
        else if (i == bsp_pkg::BIT_DEBUG && f == bsp_pkg::FUNC_1)
        begin
          alt_o = debug_wire_out_in; // R12
          alt_e = debug_wire_oe_in & st_reg.straps.debug_boot;
        end
        else if (i == bsp_pkg::BIT_HOST_IRQ && f == bsp_pkg::FUNC_3)
        begin
          alt_o = command_complete_flag_in; // R15
          alt_e = 1'b1;
        end
        else if (i >= 6 && f == bsp_pkg::FUNC_3)
        begin
          alt_o = irq_src_in[(i + 2) % 4]; // R7
          alt_e = 1'b1;
        end
        else if (i == bsp_pkg::BIT_WAKE && f == bsp_pkg::FUNC_2)
          alt_e = 1'b0; // R9
        else if (i == bsp_pkg::BIT_PORT3 && f == bsp_pkg::FUNC_3)
          alt_e = 1'b0; // slave select input
      end
      assign pin_out[i]        = alt_o;
      assign pin_oe_out[i]     = alt_e;
      assign pin_pullup_out[i] = st_reg.pull[i]; // R6
    end
  endgenerate

  // open drain reset pin: only ever pulls low
  assign reset_pin_n_out    = 1'b0; // R2
  assign reset_pin_n_oe_out = reset_bidir_en_in & reset_drive_in; // R2

  // upper bits have no pin and read their output latch
  assign fio_in_out = {st_reg.data[W-1:P], pin_s}; // R5
  assign fio_data_out = st_reg.data;
  assign debug_wire_out     = pin_s[bsp_pkg::BIT_DEBUG];
  assign host_i2c_data_out  = pin_s[bsp_pkg::BIT_I2C_DAT];
  assign host_i2c_clock_out = pin_s[bsp_pkg::BIT_I2C_CLK];
  assign slave_select_n_out = pin_s[bsp_pkg::BIT_PORT3];
  assign straps_out       = st_reg.straps; // R14
  assign straps_valid_out = st_reg.state == bsp_pkg::ST_RUN;
  assign background_debug_state_out = straps_valid_out
                                      & st_reg.straps.debug_boot;
  assign wake_irq_out   = wake_hit;
  assign wake_level_out = wake_hit ? bsp_pkg::WAKE_PRIORITY : 3'h0; // R10

  // straps stay fixed once captured
  a_straps_hold: assert property ( // R21
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    straps_valid_out && ce_in |=> $stable(straps_out))
    else $error("straps changed after capture");
  a_wake_level: assert property ( // R10
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wake_irq_out |-> wake_level_out == 3'h7)
    else $error("wake level not seven");
  a_reset_od: assert property ( // R2
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !reset_bidir_en_in |-> !reset_pin_n_oe_out)
    else $error("reset pin driven while input only");
  // port operations land in the next cycle
  a_fio_set: assert property ( // R4
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && straps_valid_out && fio_cmd_in.valid
    && fio_cmd_in.op == 2'h1 |=> (fio_data_out & $past(fio_cmd_in.data))
    == $past(fio_cmd_in.data))
    else $error("set op lost bits");
  a_fio_clear: assert property ( // R4
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ce_in && straps_valid_out && fio_cmd_in.valid
    && fio_cmd_in.op == bsp_pkg::OP_CLEAR
    |=> (fio_data_out & $past(fio_cmd_in.data)) == '0)
    else $error("clear op left bits set");
  // pin roles chosen by the straps and the mux
  a_port3_i2c: assert property ( // R17
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(straps_valid_out) && !straps_out.slave_spi
    |-> pin_oe_out[3] && !pin_out[3])
    else $error("bit three not low output in i2c mode");
  a_port3_spi: assert property ( // R13
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(straps_valid_out) && straps_out.slave_spi
    |-> !pin_oe_out[bsp_pkg::BIT_PORT3])
    else $error("slave select pin driven in spi mode");
  a_debug_wire: assert property ( // R12
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !st_reg.straps.debug_boot |-> !pin_oe_out[9] || st_reg.mux[19:18] != 2'h0)
    else $error("debug pin driven outside debug state");
  a_host_irq: assert property ( // R15
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    st_reg.mux[2*bsp_pkg::BIT_HOST_IRQ +: 2] == bsp_pkg::FUNC_3
    |-> pin_oe_out[bsp_pkg::BIT_HOST_IRQ]
    && pin_out[bsp_pkg::BIT_HOST_IRQ] == command_complete_flag_in)
    else $error("host interrupt pin not following flag");
  a_wake_input: assert property ( // R9
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    st_reg.mux[2*bsp_pkg::BIT_WAKE +: 2] == bsp_pkg::FUNC_2
    |-> !pin_oe_out[bsp_pkg::BIT_WAKE])
    else $error("wake pin driven while used as input");
  // capture timing and reset state of the pads
  a_strap_time: assert property ( // R21
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> ##[1:12] straps_valid_out)
    else $error("straps not captured in time");
  a_pull_reset: assert property ( // R6
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !straps_valid_out |-> pin_pullup_out == '0 && !pin_oe_out[3])
    else $error("pin driven or pulled before capture");
endmodule

/* File: rtl/bsp_pkg.sv */
// package for the boot strap and pin configuration block
// assumes a single 100 MHz system clock domain
package bsp_pkg;
  localparam int          FIO_WIDTH     = 16;
  localparam int          FIO_PINS      = 10;
  localparam int          SYNC_STAGES   = 3;
  localparam int          BIT_I2C_CLK   = 0;
  localparam int          BIT_I2C_DAT   = 1;
  localparam int          BIT_PORT3     = 3;
  localparam int          BIT_WAKE      = 4;
  localparam int          BIT_HOST_IRQ  = 5;
  localparam int          BIT_DEBUG     = 9;
  localparam logic [2:0]  WAKE_PRIORITY = 3'h7;
  localparam int          CLK_MHZ       = 100;
  localparam int          STRAP_WAIT_NS = 20;
  localparam int          STRAP_CYCLES  = (STRAP_WAIT_NS * CLK_MHZ + 999) / 1000;
  // fast port op codes
  localparam logic [1:0]  OP_WRITE = 2'h0;
  localparam logic [1:0]  OP_SET   = 2'h1;
  localparam logic [1:0]  OP_CLEAR = 2'h2;
  localparam logic [1:0]  OP_TOGGLE = 2'h3;
  // wake trigger modes
  localparam logic [1:0]  WAKE_RISE = 2'h0;
  localparam logic [1:0]  WAKE_FALL = 2'h1;
  localparam logic [1:0]  WAKE_HIGH = 2'h2;
  localparam logic [1:0]  WAKE_LOW  = 2'h3;
  // pin function selects, function 1 is the reset default
  localparam logic [1:0]  FUNC_1 = 2'h0;
  localparam logic [1:0]  FUNC_2 = 2'h1;
  localparam logic [1:0]  FUNC_3 = 2'h2;

  typedef struct packed {
    logic boot_app;
    logic debug_boot;
    logic slave_spi;
  } bsp_straps_s;

  typedef struct packed {
    logic                 valid;
    logic [1:0]           op;
    logic [FIO_WIDTH-1:0] data;
  } bsp_fio_cmd_s;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_LATCH = 3'h2,
    ST_RUN = 3'h4
  } bsp_state_e;
endpackage

/* File: rtl/bsp_sync.sv */
// three stage synchroniser; change accepted when stages 2 and 3 agree
// assumes the input is asynchronous to clk_sys_in
`timescale 1ns/100ps
module bsp_sync #(
  parameter int  WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } bsp_sync_s;
  bsp_sync_s st_reg;
  bsp_sync_s st_next;

  // shift chain, output follows when the last two agree
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_reg.s2[i] == st_reg.s3[i])
        st_next.q[i] = st_reg.s3[i];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_reg <= {INIT, INIT, INIT, INIT};
    else if (ce_in)
      st_reg <= st_next;
  end
  assign sync_out = st_reg.q;
endmodule

/* File: rtl/bsp_wake.sv */
// wake interrupt detector with edge or level trigger
// assumes a synchronised input on the system clock
`timescale 1ns/100ps
module bsp_wake (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       wake_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       ack_in,
  output logic            irq_out
);
  typedef struct packed {
    logic prev;
    logic pend;
  } bsp_wake_s;
  bsp_wake_s st_reg;
  bsp_wake_s st_next;
  logic      hit;

  // edge and level modes latch until ack, a held level sets it again
  always_comb
  begin
    st_next = st_reg;
    st_next.prev = wake_in;
    hit = 1'b0;
    unique case (mode_in)
      bsp_pkg::WAKE_RISE: hit = wake_in & ~st_reg.prev; // R9
      bsp_pkg::WAKE_FALL: hit = ~wake_in & st_reg.prev; // R9
      bsp_pkg::WAKE_HIGH: hit = wake_in; // R9
      bsp_pkg::WAKE_LOW:  hit = ~wake_in; // R9
    endcase
    if (ack_in)
      st_next.pend = 1'b0;
    if (hit)
      st_next.pend = 1'b1; // set wins over ack
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    // prev starts high like the synchronised pin, so no false edge
    if (!rst_n_in)
      st_reg <= '{prev: 1'b1, pend: 1'b0};
    else if (ce_in)
      st_reg <= st_next;
  end
  // taken straight from the pend register, so a wake needs a clock edge
  assign irq_out = st_reg.pend;
endmodule

/* File: tb/bsp_host.sv */
// host side model: reset pad, strap lines and wake line
// assumes device enables win over weak pull-ups on shared lines
`timescale 1ns/100ps
module bsp_host (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_lvl_in,
  input  wire logic       dbg_lvl_in,
  input  wire logic       spi_sel_in,
  input  wire logic       wake_lvl_in,
  input  wire logic       rst_oe_in,
  input  wire logic [9:0] pin_out_in,
  input  wire logic [9:0] pin_oe_in,
  output logic            reset_pin_n_out,
  output logic [9:0]      pin_in_out
);
  logic       flip_reg;
  logic [9:0] host_v;
  // released lines wander every cycle so stale values never pass
  initial flip_reg = 1'b0;
  always @(posedge clk_sys_in) flip_reg <= ~flip_reg;
  // open drain reset pad with pull-up
  assign reset_pin_n_out = rst_lvl_in & ~rst_oe_in;
  // slave select strap held through reset and after release
  always_comb
  begin
    host_v    = {10{flip_reg}};
    host_v[9] = dbg_lvl_in;
    host_v[4] = wake_lvl_in;
    host_v[3] = ~spi_sel_in;
    for (int i = 0; i < 10; i++)
      pin_in_out[i] = pin_oe_in[i] ? pin_out_in[i] : host_v[i];
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the boot strap and pin block
// assumes the host model drives the pads; inputs change at negedge
`timescale 1ns/100ps
module testbench;
  logic clk_sys_in, rst_n_in, pad, dbg, spi, wake, drv, bidir;
  logic fdw, fpw, mwe, ack, cc, hdo_in, ce, dwoe;
  logic [15:0] fdir, fpull, exp_d;
  logic [19:0] mux;
  logic [1:0]  wmode;
  logic [3:0]  isrc;
  logic [31:0] lf;
  bsp_pkg::bsp_fio_cmd_s cmd;
  wire logic rpn, rpo, rpoe, dwo, hdo, hco, sso, sv, bds, wirq;
  wire logic [9:0]  pi, po, poe, ppu;
  wire logic [15:0] fdo, fio;
  wire logic [2:0]  wlv;
  wire bsp_pkg::bsp_straps_s st;
  int n_fail, n_compared;

  bsp_host u_host (.clk_sys_in(clk_sys_in), .rst_lvl_in(pad),
    .dbg_lvl_in(dbg), .spi_sel_in(spi), .wake_lvl_in(wake),
    .rst_oe_in(rpoe), .pin_out_in(po), .pin_oe_in(poe),
    .reset_pin_n_out(rpn), .pin_in_out(pi));

  bsp_top u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ce_in(ce), .reset_pin_n_in(rpn), .reset_pin_n_out(rpo),
    .reset_pin_n_oe_out(rpoe), .reset_drive_in(drv),
    .reset_bidir_en_in(bidir), .pin_in(pi), .pin_out(po),
    .pin_oe_out(poe), .pin_pullup_out(ppu), .fio_cmd_in(cmd),
    .fio_dir_in(fdir), .fio_dir_we_in(fdw), .fio_pull_in(fpull),
    .fio_pull_we_in(fpw), .mux_sel_in(mux), .mux_we_in(mwe),
    .wake_mode_in(wmode), .wake_ack_in(ack),
    .command_complete_flag_in(cc), .irq_src_in(isrc),
    .host_i2c_data_out_in(hdo_in), .host_i2c_data_oe_in(1'b0),
    .host_i2c_clock_oe_in(1'b0), .debug_wire_out_in(1'b0),
    .debug_wire_oe_in(dwoe), .debug_wire_out(dwo),
    .host_i2c_data_out(hdo), .host_i2c_clock_out(hco),
    .slave_select_n_out(sso), .fio_data_out(fdo), .fio_in_out(fio),
    .straps_out(st), .straps_valid_out(sv),
    .background_debug_state_out(bds), .wake_irq_out(wirq),
    .wake_level_out(wlv));

  // free running system clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // reset with given straps; a set command before valid must be dropped
  task automatic boot(input logic p, input logic d, input logic s);
    int k;
    pad = p;
    dbg = d;
    spi = s;
    rst_n_in = 1'b0;
    cyc(2);
    rst_n_in = 1'b1;
    cmd = '{1'b1, bsp_pkg::OP_SET, 16'hFFFF};
    cyc(1);
    cmd.valid = 1'b0;
    k = 0;
    while (sv !== 1'b1 && k < 20)
    begin
      cyc(1);
      k++;
    end
    exp_d = 16'h0000;
    chk("valid", 16'h1, {15'h0, sv});
    chk("refused", 16'h0, fdo);
  endtask

  // one port operation taken with dir and pull writes in the same cycle
  task automatic op(input logic [1:0] o, input logic [15:0] d);
    cmd = '{1'b1, o, d};
    fdir = lf[31:16];
    fpull = ~lf[31:16];
    fdw = 1'b1;
    fpw = 1'b1;
    hdo_in = lf[5];
    cyc(1);
    case (o)
      bsp_pkg::OP_WRITE: exp_d = d;
      bsp_pkg::OP_SET:   exp_d = exp_d | d;
      bsp_pkg::OP_CLEAR: exp_d = exp_d & ~d;
      default:           exp_d = exp_d ^ d;
    endcase
    chk("fio_data", exp_d, fdo);
    chk("fio_upper", {10'h0, exp_d[15:10]}, {10'h0, fio[15:10]});
    chk("pin2_oe", {15'h0, fdir[2]}, {15'h0, poe[2]});
    chk("pin2_pull", {15'h0, fpull[2]}, {15'h0, ppu[2]});
    chk("i2c_pins", {14'h0, hdo_in, 1'b0}, {14'h0, po[1:0]});
    chk("sel_pins", 16'h2, {14'h0, dwo, sso});
    if (fdir[2])
      chk("pin2_out", {15'h0, exp_d[2]}, {15'h0, po[2]});
  endtask

  initial
  begin
    logic a;
    {pad, dbg, spi, wake, drv, bidir, fdw, fpw, mwe, ack, cc} = '0;
    {hdo_in, fdir, fpull, mux, wmode, isrc, n_fail, n_compared} = '0;
    cmd = '0;
    {ce, dwoe} = 2'b11;
    lf = 32'h5319562F;
    rst_n_in = 1'b0;
    // every strap combination, then straps must not follow the pads
    for (int i = 0; i < 8; i++)
    begin
      boot(i[0], i[1], i[2]);
      chk("straps", {13'h0, i[0], ~i[1], i[2]}, {13'h0, st});
      chk("debug_state", {15'h0, ~i[1]}, {15'h0, bds});
      chk("pullups", 16'h0, {6'h0, ppu});
      chk("oe_rest", 16'h0, {6'h0, poe & 10'h1F7});
      chk("dbg_oe", {15'h0, ~i[1]}, {15'h0, poe[9]});
      chk("pin3_oe", {15'h0, ~i[2]}, {15'h0, poe[3]});
      if (!i[2])
        chk("pin3_out", 16'h0, {15'h0, po[3]});
      {pad, dbg, spi} = ~{pad, dbg, spi};
      cyc(6);
      chk("straps_held", {13'h0, i[0], ~i[1], i[2]}, {13'h0, st});
    end
    // open drain reset drive
    for (int i = 0; i < 4; i++)
    begin
      {drv, bidir} = i[1:0];
      cyc(1);
      chk("rst_oe", {15'h0, i[0] & i[1]}, {15'h0, rpoe});
      chk("rst_out", 16'h0, {15'h0, rpo});
    end
    {drv, bidir} = 2'b00;
    boot(1'b1, 1'b1, 1'b1);
    // random back to back port operations
    for (int i = 0; i < 16; i++)
    begin
      lf = nx(lf);
      op(i < 4 ? i[1:0] : lf[17:16], lf[15:0]);
    end
    // clock enable low freezes every register
    ce = 1'b0;
    cmd = '{1'b1, bsp_pkg::OP_TOGGLE, 16'hFFFF};
    cyc(2);
    chk("ce_hold", exp_d, fdo);
    ce = 1'b1;
    {cmd.valid, fdw, fpw} = 3'b000;
    // pin4 to wake input, pins 5..8 to interrupt outputs
    mux = 20'h2A900;
    mwe = 1'b1;
    cyc(1);
    mwe = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      cc = i[0];
      isrc = lf[3:0] ^ i[3:0];
      cyc(1);
      chk("cc_pin", {15'h0, cc}, {15'h0, po[5]});
      chk("cc_oe", 16'h1, {15'h0, poe[5]});
      chk("irq_pins", {13'h0, isrc[2:0]}, {13'h0, po[8:6]});
    end
    // every wake mode: idle, hit, then acknowledge with line held
    for (int m = 0; m < 4; m++)
    begin
      a = (m == 0 || m == 2);
      wake = ~a;
      wmode = m[1:0];
      ack = 1'b1;
      cyc(8);
      ack = 1'b0;
      cyc(1);
      chk("wake_idle", 16'h0, {15'h0, wirq});
      chk("level_idle", 16'h0, {13'h0, wlv});
      wake = a;
      cyc(8);
      chk("wake_hit", 16'h1, {15'h0, wirq});
      chk("level_hit", 16'h7, {13'h0, wlv});
      ack = 1'b1;
      cyc(1);
      ack = 1'b0;
      cyc(6);
      chk("wake_after_ack", {15'h0, m[1]}, {15'h0, wirq});
    end
    report_and_stop();
  end

  // watchdog against a hang
  initial
  begin
    #200000;
    n_fail++;
    report_and_stop();
  end
endmodule
